/* File: hdl/eas_params.svh */
/*
 Constants for the external-access strap and routing block.
 Assumes it is included by the package and by the main module only.
*/
`ifndef EAS_PARAMS_SVH
`define EAS_PARAMS_SVH

// ---------------------------------------------------------------
// address map
// ---------------------------------------------------------------
`define EAS_ADDR_W 16
`define EAS_SPECIAL_LO 16'h2000
`define EAS_SPECIAL_HI 16'h207F
`define EAS_PROGRAM_LO 16'h2080
`define EAS_PROGRAM_HI 16'h7FFF
`define EAS_INTERNAL_HI 16'h1FFF
`define EAS_PORT_LO_LATCH 16'h1FFC
`define EAS_PORT_HI_LATCH 16'h1FFD
`define EAS_PORT_LO_PIN 16'h1FFE
`define EAS_PORT_HI_PIN 16'h1FFF

// ---------------------------------------------------------------
// synchroniser depth and reset values
// ---------------------------------------------------------------
`define EAS_SYNC_STAGES 2
`define EAS_RST_ADDR 16'h0000
`define EAS_RST_BIT 1'b0
`define EAS_RST_SEEN 1'b1

`endif

/* File: hdl/eas_pkg.sv */
/*
 Types for the external-access strap and routing block.
 Assumes eas_params.svh is on the include path.
*/
package eas_pkg;
`include "eas_params.svh"

   // mode latched at reset release
   typedef enum logic [1:0] {
      EAS_MODE_INT,
      EAS_MODE_EXT,
      EAS_MODE_PROG
   } eas_mode_t;

   typedef logic [`EAS_ADDR_W-1:0] eas_addr_t;
endpackage

/* File: hdl/eas_sync.sv */
/*
 Two-flop synchroniser for a group of pin levels.
 Assumes asynchronous inputs and one clock; the first flop feeds only the second;
 reset is held long enough for the pin levels to pass both stages.
*/
module eas_sync #(
   parameter int WIDTH = 2
) (
   input wire logic mclk_in,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   typedef struct packed {
      logic [WIDTH-1:0] meta;
      logic [WIDTH-1:0] sync;
   } eas_sync_state_t;

   eas_sync_state_t state_reg;
   eas_sync_state_t state_next;

   // ---------------------------------------------------------------
   // two stages, deliberately without reset
   // ---------------------------------------------------------------
   // pins must reach the second stage while reset is still held, so the
   // first edge after release sees the strap level and not a reset value
   always_comb begin
      state_next.meta = async_in;
      state_next.sync = state_reg.meta;
   end

   always_ff @(posedge mclk_in) begin
      state_reg <= state_next;
   end

   assign sync_out = state_reg.sync;
endmodule

/* File: hdl/eas_strap_route.sv */
/*
 External-access strap capture, access routing, port sharing and
 cumulative programming verification.
 Assumes one 125 MHz clock, a synchronous active-high reset, strap pins
 that are asynchronous and a core that offers one access per cycle.
*/
`include "eas_params.svh"
// Summary of operation
// R01: The strap level is caught only when reset is released and held until the next reset.
// R02: Special-purpose and program partition accesses go internal when the strap is high.
// R03: Accesses outside those partitions and the port locations route the same whatever the strap, except in programming.
// R04: A programming-voltage level on the strap at reset release enters programming mode.
// R05: In external mode the two 8-bit ports are only the address/data bus.
// R06: In external mode port latch and pin locations become external cycles at 1FFCH-1FFFH.
// R07: In internal mode the two ports may be general I/O while the bus is idle.
// R08: In programming the verify output is high if all verified and low on any failure.
// R09: Once the verify output falls it stays low until the next reset.
module eas_strap_route
   import eas_pkg::*;
(
   input wire logic mclk_in,
   input wire logic rst_in,
   input wire logic external_access_strap_in,
   input wire logic programming_voltage_in,
   input wire logic acc_req_in,
   input wire logic acc_write_in,
   input wire eas_pkg::eas_addr_t acc_addr_in,
   input wire logic bus_idle_in,
   input wire logic verify_done_in,
   input wire logic verify_ok_in,
   output eas_pkg::eas_mode_t mode_out,
   output logic acc_valid_out,
   output logic acc_write_out,
   output logic acc_external_out,
   output eas_pkg::eas_addr_t acc_addr_out,
   output logic ports_as_bus_out,
   output logic ports_gpio_allowed_out,
   output logic programming_mode_out,
   output logic cumulative_verify_out
);
   import eas_pkg::*;

   // ---------------------------------------------------------------
   // state
   // ---------------------------------------------------------------
   typedef struct packed {
      logic rst_seen;
      eas_mode_t mode;
      logic cum_ok;
      logic acc_valid;
      logic acc_write;
      logic acc_ext;
      eas_addr_t acc_addr;
   } eas_state_t;

   eas_state_t state_reg;
   eas_state_t state_next;
   logic [1:0] strap_sync;
   logic strap_hi;
   logic strap_vpp;
   logic in_partition;
   logic in_port_loc;
   logic route_ext;

   // ---------------------------------------------------------------
   // pin synchronisation
   // ---------------------------------------------------------------
   eas_sync #(
      .WIDTH(2)
   ) u_sync (
      .mclk_in(mclk_in),
      .async_in({programming_voltage_in, external_access_strap_in}),
      .sync_out(strap_sync)
   );
   assign strap_hi = strap_sync[0];
   assign strap_vpp = strap_sync[1];

   // ---------------------------------------------------------------
   // address decode
   // ---------------------------------------------------------------
   always_comb begin
      in_partition = (acc_addr_in >= `EAS_SPECIAL_LO) && (acc_addr_in <= `EAS_PROGRAM_HI);
      in_port_loc = (acc_addr_in >= `EAS_PORT_LO_LATCH) && (acc_addr_in <= `EAS_PORT_HI_PIN);
      route_ext = 1'b0;
      case (state_reg.mode)
         EAS_MODE_INT: begin
            // only the fixed map decides [R02] [R03]
            route_ext = !in_partition && !in_port_loc && (acc_addr_in > `EAS_INTERNAL_HI);
         end
         EAS_MODE_EXT: begin
            // partitions and port locations go off chip [R02] [R06]
            route_ext = in_partition || in_port_loc || (acc_addr_in > `EAS_INTERNAL_HI);
         end
         EAS_MODE_PROG: begin
            // programming keeps all accesses on chip
            route_ext = 1'b0;
         end
         default: begin
            route_ext = 1'b0;
         end
      endcase
   end

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb begin
      state_next = state_reg;
      state_next.rst_seen = 1'b0;
      // latch mode only on the first edge after release [R01] [R04]
      if (state_reg.rst_seen) begin
         if (strap_vpp) begin
            state_next.mode = EAS_MODE_PROG;
         end else if (strap_hi) begin
            state_next.mode = EAS_MODE_INT;
         end else begin
            state_next.mode = EAS_MODE_EXT;
         end
         state_next.cum_ok = 1'b1;
      end
      // a failure is sticky for the session [R08] [R09]
      if (state_reg.mode == EAS_MODE_PROG && verify_done_in && !verify_ok_in) begin
         state_next.cum_ok = 1'b0;
      end
      // routing result registered with the access
      state_next.acc_valid = acc_req_in && !state_reg.rst_seen;
      state_next.acc_write = acc_write_in;
      state_next.acc_ext = route_ext;
      // same address is kept for the remapped port locations [R06]
      state_next.acc_addr = acc_addr_in;
   end

   // ---------------------------------------------------------------
   // state register
   // ---------------------------------------------------------------
   always_ff @(posedge mclk_in) begin
      if (rst_in) begin
         state_reg.rst_seen <= `EAS_RST_SEEN;
         state_reg.mode <= EAS_MODE_INT;
         state_reg.cum_ok <= `EAS_RST_BIT;
         state_reg.acc_valid <= `EAS_RST_BIT;
         state_reg.acc_write <= `EAS_RST_BIT;
         state_reg.acc_ext <= `EAS_RST_BIT;
         state_reg.acc_addr <= `EAS_RST_ADDR;
      end else begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign mode_out = state_reg.mode;
   assign acc_valid_out = state_reg.acc_valid;
   assign acc_write_out = state_reg.acc_write;
   assign acc_external_out = state_reg.acc_ext;
   assign acc_addr_out = state_reg.acc_addr;
   assign programming_mode_out = (state_reg.mode == EAS_MODE_PROG);
   // bus-only ports in external mode [R05]
   assign ports_as_bus_out = (state_reg.mode == EAS_MODE_EXT);
   // idle gaps only; a busy bus still owns the pins [R07]
   assign ports_gpio_allowed_out = (state_reg.mode == EAS_MODE_INT) && bus_idle_in;
   // low outside programming so the shared pin stays quiet [R08]
   assign cumulative_verify_out = programming_mode_out && state_reg.cum_ok;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   sequence s_release;
      $fell(rst_in);
   endsequence

   sequence s_fail_seen;
      programming_mode_out && verify_done_in && !verify_ok_in;
   endsequence

   chk_mode_hold: assert property (@(posedge mclk_in) disable iff (rst_in) // [R01]
      !state_reg.rst_seen && !$past(state_reg.rst_seen) |-> $stable(mode_out))
      else $error("mode changed after reset release");

   chk_mode_latch: assert property (@(posedge mclk_in) disable iff (rst_in) // [R01]
      s_release |=> mode_out == ($past(strap_vpp) ? EAS_MODE_PROG
         : ($past(strap_hi) ? EAS_MODE_INT : EAS_MODE_EXT)))
      else $error("mode not latched at reset release");

   chk_part_internal: assert property (@(posedge mclk_in) disable iff (rst_in) // [R02]
      acc_req_in && !state_reg.rst_seen && mode_out == EAS_MODE_INT && in_partition
      |=> acc_valid_out && !acc_external_out)
      else $error("partition access left chip in internal mode");

   chk_part_external: assert property (@(posedge mclk_in) disable iff (rst_in) // [R02]
      acc_req_in && !state_reg.rst_seen && mode_out == EAS_MODE_EXT && in_partition
      |=> acc_valid_out && acc_external_out)
      else $error("partition access stayed internal in external mode");

   chk_other_same: assert property (@(posedge mclk_in) disable iff (rst_in) // [R03]
      acc_req_in && mode_out != EAS_MODE_PROG && !in_partition && !in_port_loc
      |=> acc_external_out == (acc_addr_out > `EAS_INTERNAL_HI))
      else $error("routing of other address depends on strap");

   chk_prog_entry: assert property (@(posedge mclk_in) disable iff (rst_in) // [R04]
      state_reg.rst_seen && strap_vpp |=> programming_mode_out [*3])
      else $error("programming mode not entered");

   chk_bus_only: assert property (@(posedge mclk_in) disable iff (rst_in) // [R05]
      mode_out == EAS_MODE_EXT |-> ports_as_bus_out && !ports_gpio_allowed_out)
      else $error("ports offered as io in external mode");

   chk_port_remap: assert property (@(posedge mclk_in) disable iff (rst_in) // [R06]
      acc_req_in && !state_reg.rst_seen && mode_out == EAS_MODE_EXT && in_port_loc
      |=> acc_external_out && acc_addr_out == $past(acc_addr_in))
      else $error("port location not remapped externally");

   chk_gpio_idle: assert property (@(posedge mclk_in) disable iff (rst_in) // [R07]
      mode_out == EAS_MODE_INT |-> ports_gpio_allowed_out == bus_idle_in)
      else $error("io permission wrong in internal mode");

   chk_verify_fall: assert property (@(posedge mclk_in) disable iff (rst_in) // [R08]
      s_fail_seen |=> !cumulative_verify_out)
      else $error("verify output not low after failure");

   chk_verify_sticky: assert property (@(posedge mclk_in) disable iff (rst_in) // [R09]
      s_fail_seen ##1 !state_reg.rst_seen |-> !cumulative_verify_out [*4])
      else $error("verify output recovered before reset");
endmodule

/* File: sim/eas_prog_model.sv */
/*
 Model of the strap pins and the programming equipment result lines.
 Assumes the bench changes its commands at the falling clock edge.
*/
module eas_prog_model (
   input wire logic mclk_in,
   input wire logic strap_high_in,
   input wire logic vpp_on_in,
   input wire logic res_req_in,
   input wire logic res_ok_in,
   output logic external_access_strap_out,
   output logic programming_voltage_out,
   output logic verify_done_out,
   output logic verify_ok_out
);
   logic last_ok_reg = 1'h0;
   // pin levels held as commanded, across the reset release too
   assign external_access_strap_out = strap_high_in;
   assign programming_voltage_out = vpp_on_in;
   // the result is valid with its strobe only; otherwise it shows the inverse
   assign verify_done_out = res_req_in;
   assign verify_ok_out = res_req_in ? res_ok_in : ~last_ok_reg;
   always_ff @(posedge mclk_in) begin
      if (res_req_in) last_ok_reg <= res_ok_in;
   end
endmodule

/* File: sim/tb.sv */
/*
 Self-checking bench for strap capture, access routing and verify output.
 Assumes the design package, the design and the model are compiled first.
*/
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import eas_pkg::*;
   localparam int N = 12;
   logic mclk_in = 1'h0, rst_in = 1'h1, strap_high = 1'h1, vpp_on = 1'h0;
   logic res_req = 1'h0, res_ok = 1'h0, acc_req_in = 1'h0, acc_write_in = 1'h0;
   logic bus_idle_in = 1'h0;
   eas_addr_t acc_addr_in = 16'h0000;
   wire logic strap_w, vpp_w, vdone_w, vok_w;
   eas_mode_t mode_out;
   logic acc_valid_out, acc_write_out, acc_external_out;
   eas_addr_t acc_addr_out;
   logic ports_as_bus_out, ports_gpio_allowed_out, programming_mode_out, cumulative_verify_out;
   int n_errors = 0, n_compared = 0;
   // ---------------------------------------------------------------
   // rows: address beside its expected external flag, per mode
   // ---------------------------------------------------------------
   typedef struct packed {
      eas_addr_t addr;
      logic ext_int;
      logic ext_ext;
   } eas_row_t;
   eas_row_t rows [N] = '{
      '{16'h2000, 1'h0, 1'h1}, '{16'h207F, 1'h0, 1'h1}, '{16'h2080, 1'h0, 1'h1},
      '{16'h7FFF, 1'h0, 1'h1}, '{16'h1FFC, 1'h0, 1'h1}, '{16'h1FFD, 1'h0, 1'h1},
      '{16'h1FFE, 1'h0, 1'h1}, '{16'h1FFF, 1'h0, 1'h1}, '{16'h0100, 1'h0, 1'h0},
      '{16'h8000, 1'h1, 1'h1}, '{16'hFFFF, 1'h1, 1'h1}, '{16'h1FFB, 1'h0, 1'h0}};

   eas_strap_route dut_u (.mclk_in(mclk_in), .rst_in(rst_in),
      .external_access_strap_in(strap_w), .programming_voltage_in(vpp_w),
      .acc_req_in(acc_req_in), .acc_write_in(acc_write_in), .acc_addr_in(acc_addr_in),
      .bus_idle_in(bus_idle_in), .verify_done_in(vdone_w), .verify_ok_in(vok_w),
      .mode_out(mode_out), .acc_valid_out(acc_valid_out), .acc_write_out(acc_write_out),
      .acc_external_out(acc_external_out), .acc_addr_out(acc_addr_out),
      .ports_as_bus_out(ports_as_bus_out), .ports_gpio_allowed_out(ports_gpio_allowed_out),
      .programming_mode_out(programming_mode_out),
      .cumulative_verify_out(cumulative_verify_out));
   eas_prog_model model_u (.mclk_in(mclk_in), .strap_high_in(strap_high), .vpp_on_in(vpp_on),
      .res_req_in(res_req), .res_ok_in(res_ok), .external_access_strap_out(strap_w),
      .programming_voltage_out(vpp_w), .verify_done_out(vdone_w), .verify_ok_out(vok_w));

   // 8 ns clock
   initial begin
      forever #4 mclk_in = ~mclk_in;
   end
   // ---------------------------------------------------------------
   // shared tasks
   // ---------------------------------------------------------------
   task automatic chk(input logic ok, input string msg);
      n_compared++;
      if (ok !== 1'h1) begin
         n_errors++;
         $display("mismatch at %0t ns: %s", $time, msg);
      end
   endtask
   // entered at a falling edge; leaves the request up so calls run back to back
   task automatic acc(input eas_addr_t a, input logic w, input logic e);
      acc_req_in = 1'h1;
      acc_addr_in = a;
      acc_write_in = w;
      @(negedge mclk_in);
      chk(acc_valid_out === 1'h1 && acc_external_out === e && acc_addr_out === a
         && acc_write_out === w, "routed access");
   endtask
   // reset held long enough for the pin synchroniser to settle
   task automatic boot(input logic s, input logic v);
      @(negedge mclk_in);
      rst_in = 1'h1;
      strap_high = s;
      vpp_on = v;
      repeat (12) @(negedge mclk_in);
      rst_in = 1'h0;
      acc_req_in = 1'h1;
      @(negedge mclk_in);
      acc_req_in = 1'h0;
      chk(acc_valid_out === 1'h0, "request at release taken");
   endtask
   task automatic mode_chk(input eas_mode_t m);
      chk(mode_out === m && programming_mode_out === (m == EAS_MODE_PROG), "mode");
      bus_idle_in = 1'h1;
      @(negedge mclk_in);
      chk(ports_as_bus_out === (m == EAS_MODE_EXT), "ports as bus");
      chk(ports_gpio_allowed_out === (m == EAS_MODE_INT), "gpio when idle");
      bus_idle_in = 1'h0;
      @(negedge mclk_in);
      chk(ports_gpio_allowed_out === 1'h0, "gpio while busy");
   endtask
   task automatic vfy(input logic ok, input logic e);
      @(negedge mclk_in);
      res_req = 1'h1;
      res_ok = ok;
      @(negedge mclk_in);
      res_req = 1'h0;
      chk(cumulative_verify_out === e, "verify level");
   endtask
   task automatic stop_test;
      $display("errors %0d compared %0d", n_errors, n_compared);
      if (n_errors == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask
   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial begin
      for (int md = 0; md < 2; md++) begin
         boot(md == 0, 1'h0);
         mode_chk(md == 0 ? EAS_MODE_INT : EAS_MODE_EXT);
         for (int i = 0; i < N; i++) begin
            acc(rows[i].addr, i[0], md == 0 ? rows[i].ext_int : rows[i].ext_ext);
         end
         // a strap change after release must not move the routing
         acc_req_in = 1'h0;
         strap_high = ~strap_high;
         repeat (4) @(negedge mclk_in);
         acc(16'h2000, 1'h0, md[0]);
         acc_req_in = 1'h0;
         mode_chk(md == 0 ? EAS_MODE_INT : EAS_MODE_EXT);
      end
      // programming voltage wins over a low strap
      boot(1'h0, 1'h1);
      mode_chk(EAS_MODE_PROG);
      chk(cumulative_verify_out === 1'h1, "verify start");
      vfy(1'h1, 1'h1);
      vfy(1'h0, 1'h0);
      vfy(1'h1, 1'h0);
      vfy(1'h1, 1'h0);
      boot(1'h1, 1'h0);
      vfy(1'h1, 1'h0);
      stop_test();
   end
endmodule
